// ### shared/udif_consts.svh
// register offsets, field positions, reset values and timing counts of the usb flag block
`ifndef UDIF_CONSTS_SVH
`define UDIF_CONSTS_SVH

`define UDIF_OFS_FIFO_WP 8'h04
`define UDIF_OFS_FIFO_RP 8'h05
`define UDIF_OFS_IRQ_EN_A 8'h06
`define UDIF_OFS_IRQ_EN_B 8'h07
`define UDIF_OFS_FLAGS_A_CLR 8'h0A
`define UDIF_OFS_FLAGS_A_SET 8'h0B
`define UDIF_OFS_FLAGS_B_CLR 8'h0C
`define UDIF_OFS_FLAGS_B_SET 8'h0D
`define UDIF_OFS_DESC_LO 8'h16
`define UDIF_OFS_DESC_HI 8'h17
`define UDIF_OFS_EP_STATUS 8'h18
`define UDIF_OFS_TRIM_LO 8'h3A
`define UDIF_OFS_TRIM_HI 8'h3B

`define UDIF_A_FRAME 7
`define UDIF_A_IDLE 6
`define UDIF_A_WAKE 5
`define UDIF_A_RESET 4
`define UDIF_A_CRC 3
`define UDIF_A_UNDER 2
`define UDIF_A_OVER 1
`define UDIF_A_STALL 0

`define UDIF_B_TRN 1
`define UDIF_B_SETUP 0

`define UDIF_EN_FRAME 7
`define UDIF_EN_BUSEV 6
`define UDIF_EN_BUSERR 5
`define UDIF_EN_STALL 4
`define UDIF_EN_LVL_HI 1
`define UDIF_EN_LVL_LO 0
`define UDIF_EN_TRN 1
`define UDIF_EN_SETUP 0

`define UDIF_EN_A_MASK 8'hF3
`define UDIF_EN_B_MASK 8'h03
`define UDIF_FLAGS_B_MASK 8'h03
`define UDIF_DESC_LO_MASK 8'hFE
`define UDIF_EP_CLEAR_BIT 7
`define UDIF_BYTE_RESET 8'h00
`define UDIF_PTR_RESET 5'h00
`define UDIF_PTR_ONE 5'h01

`define UDIF_DESC_IN_OFS 16'h0008

`define UDIF_CLK_MHZ 25
`define UDIF_SE0_NS 2500
`define UDIF_SE0_CYCLES ((`UDIF_SE0_NS * `UDIF_CLK_MHZ + 999) / 1000)
`define UDIF_IDLE_US 3000
`define UDIF_IDLE_CYCLES (`UDIF_IDLE_US * `UDIF_CLK_MHZ)

`endif

// ### shared/udif_pkg.sv
// types shared by the usb flag block
package udif_pkg;

    // one-cycle events from the serial engine on the same clock
    typedef struct packed {
        logic frame_start;
        logic iso_crc_err;
        logic in_no_data;
        logic out_not_ready;
        logic stall_sent;
        logic setup_ok;
        logic transfer_ok;
        logic ep_in;
        logic [3:0] ep;
    } udif_evt_t;

    // descriptor lookup request
    typedef struct packed {
        logic ep_in;
        logic [3:0] ep;
    } udif_desc_req_t;

    typedef enum logic {
        UDIF_ACTIVE,
        UDIF_SUSPENDED
    } udif_bus_state_t;

endpackage

// ### src/udif_top.sv
// usb device interrupt enables, event flags, pad trim and descriptor addressing
//
// What this block does
// - bus error enable plus level raises request on crc, underflow or overflow flag
// - stall enable plus level raises request on the stall handshake flag
// - two-bit level selects priority; zero blocks all requests; each source needs enable
// - transfer done enable raises request for finished in and out transactions
// - setup done enable raises request for finished setup transactions
// - flag set a has clear and set aliases, same read value, zeros ignored
// - flag set b: one at set alias sets, one at clear alias clears
// - frame start flag sets on each received start of frame packet
// - bus idle flag sets after three milliseconds of idle bus
// - non-idle bus while suspended sets wake flag and wakes the processor
// - bus reset flag sets when a reset condition is seen on the lines
// - iso checksum error flag sets on bad crc to an isochronous endpoint
// - in no data flag sets when addressed in endpoint has nothing to send
// - out not ready flag sets when addressed out endpoint cannot take data
// - stall handshake flag sets whenever a stall answers in or out
// - transfer done flag stands while the completion fifo holds entries
// - setup done flag sets when a setup transaction completes
// - pointer writes clear transfer done; draining reads clear it with fifo enabled
// - sixteen endpoints, out descriptor at base plus sixteen times number, in eight later
// - endpoint stall status bit sets on stall answer, clears on written one
// - same bit flags crc error on isochronous out endpoints, clears on one
// - reset condition is both lines at zero for at least 2.5 microseconds
`timescale 1ns/10ps
`include "udif_consts.svh"

module udif_top
    import udif_pkg::*;
#(
    parameter int SUSPEND_CYCLES = `UDIF_IDLE_CYCLES
) (
    input wire logic clock, // 25 MHz clock
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_write, // write strobe
    input wire logic reg_read, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic dp_pin, // d+ line level
    input wire logic dm_pin, // d- line level
    input wire logic low_speed, // low speed idle polarity
    input wire logic fifo_enable, // completion fifo in use
    input udif_evt_t link_evt, // serial engine events
    input udif_desc_req_t desc_req, // endpoint to look up
    output logic [15:0] desc_addr, // descriptor byte address
    output logic [15:0] pad_trim, // pad calibration value
    output logic irq_request, // interrupt request level
    output logic [1:0] irq_level, // interrupt priority level
    output logic bus_suspended, // bus in suspend state
    output logic wake_request // wake processor from sleep
);

    localparam logic [5:0] SE0_LIMIT = 6'(`UDIF_SE0_CYCLES);
    localparam logic [16:0] IDLE_LIMIT = 17'(SUSPEND_CYCLES);

    function automatic logic [7:0] flag_next(
        input logic [7:0] cur,
        input logic [7:0] clr,
        input logic [7:0] set,
        input logic [7:0] hw
    );
        return (cur & ~clr) | set | hw;
    endfunction

    function automatic logic [31:0] ep_onehot(input logic in_dir, input logic [3:0] ep);
        return 32'h00000001 << {in_dir, ep};
    endfunction

    function automatic logic [15:0] desc_calc(
        input logic [15:0] base,
        input logic [3:0] ep,
        input logic in_dir
    );
        logic [15:0] a;
        a = base + {8'h00, ep, 4'h0};
        if (in_dir) begin
            a = a + `UDIF_DESC_IN_OFS;
        end
        return a;
    endfunction

    // register access decode
    logic wr_fifo_wp;
    logic wr_fifo_rp;
    logic rd_fifo_rp;
    logic wr_en_a;
    logic wr_en_b;
    logic wr_a_clr;
    logic wr_a_set;
    logic wr_b_clr;
    logic wr_b_set;
    logic wr_desc_lo;
    logic wr_desc_hi;
    logic wr_ep_status;
    logic wr_trim_lo;
    logic wr_trim_hi;

    assign wr_fifo_wp = reg_write && (reg_addr == `UDIF_OFS_FIFO_WP);
    assign wr_fifo_rp = reg_write && (reg_addr == `UDIF_OFS_FIFO_RP);
    assign rd_fifo_rp = reg_read && (reg_addr == `UDIF_OFS_FIFO_RP);
    assign wr_en_a = reg_write && (reg_addr == `UDIF_OFS_IRQ_EN_A);
    assign wr_en_b = reg_write && (reg_addr == `UDIF_OFS_IRQ_EN_B);
    assign wr_a_clr = reg_write && (reg_addr == `UDIF_OFS_FLAGS_A_CLR);
    assign wr_a_set = reg_write && (reg_addr == `UDIF_OFS_FLAGS_A_SET);
    assign wr_b_clr = reg_write && (reg_addr == `UDIF_OFS_FLAGS_B_CLR);
    assign wr_b_set = reg_write && (reg_addr == `UDIF_OFS_FLAGS_B_SET);
    assign wr_desc_lo = reg_write && (reg_addr == `UDIF_OFS_DESC_LO);
    assign wr_desc_hi = reg_write && (reg_addr == `UDIF_OFS_DESC_HI);
    assign wr_ep_status = reg_write && (reg_addr == `UDIF_OFS_EP_STATUS);
    assign wr_trim_lo = reg_write && (reg_addr == `UDIF_OFS_TRIM_LO);
    assign wr_trim_hi = reg_write && (reg_addr == `UDIF_OFS_TRIM_HI);

    // line synchronisers: a level counts once stages two and three agree
    logic [2:0] dp_sync;
    logic [2:0] dm_sync;
    logic line_dp;
    logic line_dm;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dp_sync <= 3'h0;
            dm_sync <= 3'h0;
        end else begin
            dp_sync <= {dp_sync[1:0], dp_pin};
            dm_sync <= {dm_sync[1:0], dm_pin};
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            line_dp <= 1'b0;
            line_dm <= 1'b0;
        end else begin
            if (dp_sync[2] == dp_sync[1]) begin
                line_dp <= dp_sync[2];
            end
            if (dm_sync[2] == dm_sync[1]) begin
                line_dm <= dm_sync[2];
            end
        end
    end

    logic line_se0;
    logic line_idle;

    assign line_se0 = !line_dp && !line_dm;
    assign line_idle = low_speed ? (!line_dp && line_dm) : (line_dp && !line_dm);

    // reset condition timer
    logic [5:0] se0_count;
    logic reset_evt;

    assign reset_evt = line_se0 && (se0_count == SE0_LIMIT - 6'h01);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            se0_count <= 6'h00;
        end else if (!line_se0) begin
            se0_count <= 6'h00;
        end else if (se0_count != SE0_LIMIT) begin
            se0_count <= se0_count + 6'h01;
        end
    end

    // idle timer and suspend state
    logic [16:0] idle_count;
    udif_bus_state_t bus_state;
    logic idle_evt;
    logic wake_evt;

    assign idle_evt = line_idle && (idle_count == IDLE_LIMIT - 17'h00001) &&
        (bus_state == UDIF_ACTIVE);
    assign wake_evt = !line_idle && (bus_state == UDIF_SUSPENDED);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            idle_count <= 17'h00000;
        end else if (!line_idle) begin
            idle_count <= 17'h00000;
        end else if (idle_count != IDLE_LIMIT) begin
            idle_count <= idle_count + 17'h00001;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_state <= UDIF_ACTIVE;
        end else begin
            case (bus_state)
                UDIF_ACTIVE: begin
                    if (idle_evt) begin
                        bus_state <= UDIF_SUSPENDED;
                    end
                end
                UDIF_SUSPENDED: begin
                    if (wake_evt) begin
                        bus_state <= UDIF_ACTIVE;
                    end
                end
                default: begin
                    bus_state <= UDIF_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_suspended <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            bus_suspended <= (bus_state == UDIF_SUSPENDED) && !wake_evt;
            wake_request <= wake_evt;
        end
    end

    // enable registers
    logic [7:0] irq_enable_a;
    logic [7:0] irq_enable_b;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_enable_a <= `UDIF_BYTE_RESET;
        end else if (wr_en_a) begin
            irq_enable_a <= reg_wdata & `UDIF_EN_A_MASK;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_enable_b <= `UDIF_BYTE_RESET;
        end else if (wr_en_b) begin
            irq_enable_b <= reg_wdata & `UDIF_EN_B_MASK;
        end
    end

    // flag set a
    logic [7:0] event_flags_a;
    logic [7:0] hw_a;

    always_comb begin
        hw_a = 8'h00;
        hw_a[`UDIF_A_FRAME] = link_evt.frame_start;
        hw_a[`UDIF_A_IDLE] = idle_evt;
        hw_a[`UDIF_A_WAKE] = wake_evt;
        hw_a[`UDIF_A_RESET] = reset_evt;
        hw_a[`UDIF_A_CRC] = link_evt.iso_crc_err;
        hw_a[`UDIF_A_UNDER] = link_evt.in_no_data;
        hw_a[`UDIF_A_OVER] = link_evt.out_not_ready;
        hw_a[`UDIF_A_STALL] = link_evt.stall_sent;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            event_flags_a <= `UDIF_BYTE_RESET;
        end else begin
            event_flags_a <= flag_next(event_flags_a,
                wr_a_clr ? reg_wdata : 8'h00,
                wr_a_set ? reg_wdata : 8'h00,
                hw_a);
        end
    end

    // completion fifo pointers
    logic [4:0] fifo_wp;
    logic [4:0] fifo_rp;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_drained;
    logic ptr_flush;

    assign ptr_flush = wr_fifo_wp || wr_fifo_rp;
    assign fifo_push = link_evt.transfer_ok && fifo_enable && (fifo_wp + 5'h01 != fifo_rp);
    assign fifo_pop = rd_fifo_rp && fifo_enable && (fifo_rp != fifo_wp);
    assign fifo_drained = fifo_pop && (fifo_rp + 5'h01 == fifo_wp) && !fifo_push;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fifo_wp <= `UDIF_PTR_RESET;
        end else if (ptr_flush) begin
            fifo_wp <= fifo_push ? `UDIF_PTR_ONE : `UDIF_PTR_RESET;
        end else if (fifo_push) begin
            fifo_wp <= fifo_wp + 5'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fifo_rp <= `UDIF_PTR_RESET;
        end else if (ptr_flush) begin
            fifo_rp <= `UDIF_PTR_RESET;
        end else if (fifo_pop) begin
            fifo_rp <= fifo_rp + 5'h01;
        end
    end

    // flag set b
    logic [7:0] event_flags_b;
    logic [7:0] hw_b;
    logic [7:0] clr_b;

    always_comb begin
        hw_b = 8'h00;
        hw_b[`UDIF_B_TRN] = link_evt.transfer_ok;
        hw_b[`UDIF_B_SETUP] = link_evt.setup_ok;
        clr_b = wr_b_clr ? reg_wdata : 8'h00;
        clr_b[`UDIF_B_TRN] = clr_b[`UDIF_B_TRN] || ptr_flush || fifo_drained;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            event_flags_b <= `UDIF_BYTE_RESET;
        end else begin
            event_flags_b <= flag_next(event_flags_b, clr_b,
                wr_b_set ? reg_wdata : 8'h00, hw_b) & `UDIF_FLAGS_B_MASK;
        end
    end

    // interrupt request
    logic [1:0] level;
    logic any_source;

    assign level = irq_enable_a[`UDIF_EN_LVL_HI:`UDIF_EN_LVL_LO];

    always_comb begin
        any_source = 1'b0;
        if (irq_enable_a[`UDIF_EN_FRAME] && event_flags_a[`UDIF_A_FRAME]) begin
            any_source = 1'b1;
        end
        if (irq_enable_a[`UDIF_EN_BUSEV] && (event_flags_a[`UDIF_A_IDLE] ||
            event_flags_a[`UDIF_A_WAKE] || event_flags_a[`UDIF_A_RESET])) begin
            any_source = 1'b1;
        end
        if (irq_enable_a[`UDIF_EN_BUSERR] && (event_flags_a[`UDIF_A_CRC] ||
            event_flags_a[`UDIF_A_UNDER] || event_flags_a[`UDIF_A_OVER])) begin
            any_source = 1'b1;
        end
        if (irq_enable_a[`UDIF_EN_STALL] && event_flags_a[`UDIF_A_STALL]) begin
            any_source = 1'b1;
        end
        if (irq_enable_b[`UDIF_EN_TRN] && event_flags_b[`UDIF_B_TRN]) begin
            any_source = 1'b1;
        end
        if (irq_enable_b[`UDIF_EN_SETUP] && event_flags_b[`UDIF_B_SETUP]) begin
            any_source = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_request <= 1'b0;
            irq_level <= 2'h0;
        end else begin
            irq_request <= any_source && (level != 2'h0);
            irq_level <= level;
        end
    end

    // endpoint status bits, indexed by direction and number
    logic [31:0] ep_status;
    logic [4:0] ep_select;
    logic [31:0] ep_set;
    logic [31:0] ep_clr;

    always_comb begin
        ep_set = 32'h00000000;
        ep_clr = 32'h00000000;
        if (link_evt.stall_sent) begin
            ep_set = ep_set | ep_onehot(link_evt.ep_in, link_evt.ep);
        end
        if (link_evt.iso_crc_err && !link_evt.ep_in) begin
            ep_set = ep_set | ep_onehot(1'b0, link_evt.ep);
        end
        if (wr_ep_status && reg_wdata[`UDIF_EP_CLEAR_BIT]) begin
            ep_clr = ep_onehot(reg_wdata[4], reg_wdata[3:0]);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ep_status <= 32'h00000000;
        end else begin
            ep_status <= (ep_status & ~ep_clr) | ep_set;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ep_select <= 5'h00;
        end else if (wr_ep_status) begin
            ep_select <= reg_wdata[4:0];
        end
    end

    // descriptor table base and address calculation
    logic [15:0] descriptor_table_base;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            descriptor_table_base <= 16'h0000;
        end else if (wr_desc_lo) begin
            descriptor_table_base[7:0] <= reg_wdata & `UDIF_DESC_LO_MASK;
        end else if (wr_desc_hi) begin
            descriptor_table_base[15:8] <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            desc_addr <= 16'h0000;
        end else begin
            desc_addr <= desc_calc(descriptor_table_base, desc_req.ep, desc_req.ep_in);
        end
    end

    // pad trim
    logic [7:0] pad_trim_low;
    logic [7:0] pad_trim_high;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pad_trim_low <= `UDIF_BYTE_RESET;
            pad_trim_high <= `UDIF_BYTE_RESET;
        end else if (wr_trim_lo) begin
            pad_trim_low <= reg_wdata;
        end else if (wr_trim_hi) begin
            pad_trim_high <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pad_trim <= 16'h0000;
        end else begin
            pad_trim <= {pad_trim_high, pad_trim_low};
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (!reg_read) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == `UDIF_OFS_FIFO_WP) begin
            reg_rdata <= {3'h0, fifo_wp};
        end else if (reg_addr == `UDIF_OFS_FIFO_RP) begin
            reg_rdata <= {3'h0, fifo_rp};
        end else if (reg_addr == `UDIF_OFS_IRQ_EN_A) begin
            reg_rdata <= irq_enable_a;
        end else if (reg_addr == `UDIF_OFS_IRQ_EN_B) begin
            reg_rdata <= irq_enable_b;
        end else if ((reg_addr == `UDIF_OFS_FLAGS_A_CLR) ||
                     (reg_addr == `UDIF_OFS_FLAGS_A_SET)) begin
            reg_rdata <= event_flags_a;
        end else if ((reg_addr == `UDIF_OFS_FLAGS_B_CLR) ||
                     (reg_addr == `UDIF_OFS_FLAGS_B_SET)) begin
            reg_rdata <= event_flags_b;
        end else if (reg_addr == `UDIF_OFS_DESC_LO) begin
            reg_rdata <= descriptor_table_base[7:0];
        end else if (reg_addr == `UDIF_OFS_DESC_HI) begin
            reg_rdata <= descriptor_table_base[15:8];
        end else if (reg_addr == `UDIF_OFS_EP_STATUS) begin
            reg_rdata <= {ep_status[ep_select], 2'h0, ep_select};
        end else if (reg_addr == `UDIF_OFS_TRIM_LO) begin
            reg_rdata <= pad_trim_low;
        end else if (reg_addr == `UDIF_OFS_TRIM_HI) begin
            reg_rdata <= pad_trim_high;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ### verification/tb_top.sv
// self-checking bench for the usb flag block
`timescale 1ns/10ps
module tb_top;
    import udif_pkg::*;
    logic clock, resetn, reg_write, reg_read, low_speed, fifo_enable;
    logic irq_request, bus_suspended, wake_request, dp_pin, dm_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] line_mode, irq_level;
    logic [15:0] desc_addr, pad_trim;
    udif_evt_t link_evt;
    udif_desc_req_t desc_req;
    int n_fail = 0;
    int n_compared = 0;
    udif_top #(.SUSPEND_CYCLES(50)) dut (.clock, .resetn, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .dp_pin, .dm_pin, .low_speed, .fifo_enable,
        .link_evt, .desc_req, .desc_addr, .pad_trim, .irq_request, .irq_level,
        .bus_suspended, .wake_request);
    udif_host_model host (.line_mode, .low_speed, .dp_pin, .dm_pin);
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(nm, {8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic ev(input logic [11:0] e);
        @(posedge clock);
        link_evt <= udif_evt_t'(e);
        @(posedge clock);
        link_evt <= '0;
    endtask
    task automatic t_regs;
        logic [7:0] a [6] = '{8'h06, 8'h07, 8'h0A, 8'h0C, 8'h3A, 8'h30};
        foreach (a[i]) rchk("reset value", a[i], 8'h00);
        wr(8'h07, 8'hFF);
        rchk("enable b reserved", 8'h07, 8'h03);
        wr(8'h07, 8'h00);
        $display("regs done");
    endtask
    task automatic t_flags;
        logic [7:0] m;
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? 8'h80 : 8'h08 >> (i - 1);
            wr(8'h0A, 8'hFF);
            ev(12'h800 >> i);
            rchk("flags a", 8'h0A, m);
            rchk("flags a alias", 8'h0B, m);
            wr(8'h0A, 8'h00);
            rchk("flags a zero write", 8'h0A, m);
        end
        wr(8'h18, 8'h00);
        rchk("ep stall", 8'h18, 8'h80);
        wr(8'h18, 8'h80);
        rchk("ep stall clear", 8'h18, 8'h00);
        ev(12'h405);
        wr(8'h18, 8'h05);
        rchk("ep crc", 8'h18, 8'h85);
        wr(8'h18, 8'h85);
        rchk("ep crc clear", 8'h18, 8'h05);
        wr(8'h0A, 8'hFF);
        wr(8'h0B, 8'h40);
        rchk("flags a set", 8'h0A, 8'h40);
        wr(8'h0A, 8'hFF);
        wr(8'h0D, 8'hFF);
        rchk("flags b set", 8'h0C, 8'h03);
        wr(8'h0C, 8'h02);
        rchk("flags b clear", 8'h0D, 8'h01);
        wr(8'h0C, 8'h01);
        ev(12'h040);
        rchk("setup done", 8'h0C, 8'h01);
        @(posedge clock) {reg_write, reg_addr, reg_wdata} <= {1'b1, 8'h0C, 8'h01};
        link_evt <= 12'h040;
        @(posedge clock) {reg_write, link_evt} <= 13'h0000;
        rchk("set beats clear", 8'h0C, 8'h01);
        wr(8'h0C, 8'hFF);
        $display("flags done");
    endtask
    task automatic t_irq;
        logic [7:0] ea [4] = '{8'h20, 8'h10, 8'h00, 8'h00};
        logic [7:0] eb [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
        logic [11:0] ee [4] = '{12'h100, 12'h080, 12'h040, 12'h020};
        logic [7:0] lv;
        for (int i = 0; i < 4; i++) begin
            lv = 8'(i % 3 + 1);
            wr(8'h06, ea[i]);
            wr(8'h07, eb[i]);
            ev(ee[i]);
            tick(3);
            #1 chk("request level zero", {15'h0, irq_request}, 16'h0);
            wr(8'h06, ea[i] | lv);
            tick(3);
            #1 chk("request", {15'h0, irq_request}, 16'h1);
            chk("level", {14'h0, irq_level}, {8'h00, lv});
            wr(8'h0A, 8'hFF);
            wr(8'h0C, 8'hFF);
            tick(3);
            #1 chk("request cleared", {15'h0, irq_request}, 16'h0);
        end
        wr(8'h06, 8'h00);
        $display("irq done");
    endtask
    task automatic t_fifo;
        @(posedge clock);
        fifo_enable <= 1'b1;
        ev(12'h020);
        ev(12'h020);
        rchk("fifo pending", 8'h0C, 8'h02);
        rchk("fifo pop", 8'h05, 8'h00);
        rchk("fifo one left", 8'h0C, 8'h02);
        rchk("fifo pop", 8'h05, 8'h01);
        rchk("fifo drained", 8'h0C, 8'h00);
        ev(12'h020);
        wr(8'h04, 8'h00);
        rchk("fifo flush", 8'h0C, 8'h00);
        @(posedge clock) fifo_enable <= 1'b0;
        $display("fifo done");
    endtask
    task automatic t_trim_desc;
        wr(8'h3A, 8'hA5);
        wr(8'h3B, 8'h5C);
        tick(2);
        #1 chk("pad trim", pad_trim, 16'h5CA5);
        rchk("trim high", 8'h3B, 8'h5C);
        wr(8'h16, 8'h21);
        wr(8'h17, 8'h12);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock) desc_req <= {i[0], i[1] ? 4'hF : 4'h3};
            tick(3);
            #1 chk("descriptor", desc_addr, 16'h1220 + (i[1] ? 16'h00F0 : 16'h0030)
                + (i[0] ? 16'h0008 : 16'h0000));
        end
        $display("trim and descriptor done");
    endtask
    task automatic t_lines;
        wr(8'h0A, 8'hFF);
        line_mode <= 2'h2;
        tick(80);
        line_mode <= 2'h0;
        rchk("bus reset flag", 8'h0A, 8'h10);
        for (int s = 0; s < 2; s++) begin
            wr(8'h0A, 8'hFF);
            low_speed <= s[0];
            line_mode <= 2'h1;
            tick(70);
            #1 chk("suspended", {15'h0, bus_suspended}, 16'h1);
            rchk("idle flag", 8'h0A, 8'h40);
            @(posedge clock);
            line_mode <= 2'h0;
            tick(5);
            #1 chk("wake pulse", {15'h0, wake_request}, 16'h1);
            rchk("wake flag", 8'h0A, 8'h60);
        end
        $display("lines done");
    endtask
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        {resetn, reg_write, reg_read, low_speed, fifo_enable} = 5'h00;
        {reg_addr, reg_wdata, line_mode} = 18'h00000;
        link_evt = '0;
        desc_req = '0;
        tick(10);
        resetn <= 1'b1;
        t_regs;
        t_flags;
        t_irq;
        t_fifo;
        t_trim_desc;
        t_lines;
        wrap_up;
    end
    initial begin
        tick(4000);
        n_fail++;
        wrap_up;
    end
endmodule
bind udif_top udif_props chk (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .desc_addr, .pad_trim, .irq_request, .irq_level,
    .bus_suspended, .wake_request);

// ### verification/udif_host_model.sv
// host side model driving the usb line levels
`timescale 1ns/10ps
module udif_host_model (
    input wire logic [1:0] line_mode, // 0 k state, 1 idle, 2 reset
    input wire logic low_speed, // idle polarity
    output logic dp_pin, // d+ level
    output logic dm_pin // d- level
);
    always_comb begin
        case (line_mode)
            2'h1: {dp_pin, dm_pin} = {~low_speed, low_speed};
            2'h2: {dp_pin, dm_pin} = 2'b00;
            default: {dp_pin, dm_pin} = {low_speed, ~low_speed};
        endcase
    end
endmodule

// ### verification/udif_props.sv
// port assertions for the usb flag block
`timescale 1ns/10ps
module udif_props (
    input wire logic clock, // clock
    input wire logic resetn, // reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // data
    input wire logic reg_write, // write
    input wire logic reg_read, // read
    input wire logic [7:0] reg_rdata, // read data
    input wire logic [15:0] desc_addr, // descriptor
    input wire logic [15:0] pad_trim, // trim
    input wire logic irq_request, // request
    input wire logic [1:0] irq_level, // level
    input wire logic bus_suspended, // suspend
    input wire logic wake_request // wake
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    sequence s_wake;
        wake_request;
    endsequence
    sequence s_wr(logic [7:0] a);
        reg_write && reg_addr == a;
    endsequence
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_gate;
        irq_level == 2'h0 && $past(irq_level) == 2'h0 |-> !irq_request;
    endproperty
    a_gate: assert property (p_gate) else $error("request at level zero");
    property p_level;
        s_wr(8'h06) |-> ##2 irq_level == $past(reg_wdata[1:0], 2);
    endproperty
    a_level: assert property (p_level) else $error("level not applied");
    property p_trim_lo;
        s_wr(8'h3A) |-> ##2 pad_trim[7:0] == $past(reg_wdata, 2);
    endproperty
    a_trim_lo: assert property (p_trim_lo) else $error("trim low not applied");
    property p_trim_hi;
        s_wr(8'h3B) |-> ##2 pad_trim[15:8] == $past(reg_wdata, 2);
    endproperty
    a_trim_hi: assert property (p_trim_hi) else $error("trim high not applied");
    property p_wake_pulse;
        s_wake |=> !wake_request;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
    property p_wake_exit;
        s_wake |=> !bus_suspended;
    endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("still suspended");
    property p_desc_even;
        desc_addr[0] == 1'b0;
    endproperty
    a_desc_even: assert property (p_desc_even) else $error("odd descriptor");
endmodule
